// [src/fdhq_map.vh]
`ifndef FDHQ_MAP_VH
`define FDHQ_MAP_VH

// APB register byte offsets.
`define FDHQ_OFF_CTRL 8'h00
`define FDHQ_OFF_STATUS 8'h04
`define FDHQ_OFF_TXDATA 8'h08
`define FDHQ_OFF_RXDATA 8'h0c
`define FDHQ_OFF_INT_STATUS 8'h10
`define FDHQ_OFF_INT_CLEAR 8'h14
`define FDHQ_OFF_INT_ENABLE 8'h18
`define FDHQ_OFF_COUNTS 8'h1c

// Control register fields.
`define FDHQ_CTRL_MODE_LO 0
`define FDHQ_CTRL_MODE_HI 1
`define FDHQ_CTRL_DMA_MODE 2
`define FDHQ_CTRL_START 3
`define FDHQ_CTRL_RESET 32'h0000_0000

// Operating mode codes.
`define FDHQ_MODE_BASE 2'h0
`define FDHQ_MODE_SPECIAL 2'h1
`define FDHQ_MODE_COMPAT 2'h2

// Operation register fields, loaded from the two low host data bits.
`define FDHQ_OPR_DMA_EN 0
`define FDHQ_OPR_RESET 2'h0
`define FDHQ_CCR_RESET 2'h0

// Data rate codes held in the control register.
`define FDHQ_RATE_500K 2'h0
`define FDHQ_RATE_300K 2'h1
`define FDHQ_RATE_250K 2'h2
`define FDHQ_RATE_125K 2'h3

// Interrupt status bit positions.
`define FDHQ_EV_DONE 0
`define FDHQ_EV_HOST_WR 1
`define FDHQ_EV_FLUX 2
`define FDHQ_EV_OPR_LOAD 3
`define FDHQ_EV_CCR_LOAD 4
`define FDHQ_EV_WIDTH 5

// Timing: system clock and the bit cell rates.
`define FDHQ_CLK_HZ 20000000
`define FDHQ_SECOND_CLK_HZ 9600000
`define FDHQ_RATE_500K_HZ 500000
`define FDHQ_RATE_300K_HZ 300000
`define FDHQ_RATE_250K_HZ 250000
`define FDHQ_RATE_125K_HZ 125000
`define FDHQ_DIV_500K (`FDHQ_CLK_HZ / `FDHQ_RATE_500K_HZ)
`define FDHQ_DIV_250K (`FDHQ_CLK_HZ / `FDHQ_RATE_250K_HZ)
`define FDHQ_DIV_125K (`FDHQ_CLK_HZ / `FDHQ_RATE_125K_HZ)
`define FDHQ_DIV_300K (`FDHQ_SECOND_CLK_HZ / `FDHQ_RATE_300K_HZ)

`endif

// [src/fdhq_port.v]
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "fdhq_map.vh"

module fdhq_port (
  input wire clk_sys,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output reg irq,
  input wire host_rd_n,
  input wire host_wr_n,
  input wire host_cs_n,
  input wire host_a0,
  input wire [7:0] host_db_in,
  output reg [7:0] host_db_out,
  output reg host_db_oe,
  input wire dma_acknowledge_in_n,
  input wire transfer_count_done,
  output reg dma_request,
  output reg dma_request_oe,
  output reg host_irq,
  output reg host_irq_oe,
  input wire operation_reg_load_decode_n,
  input wire control_reg_load_decode_n,
  input wire media_swap_readback_enable_n,
  input wire media_swap_status_n,
  input wire raw_read_stream,
  input wire second_rate_clock
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [1:0] mode;
  reg dma_mode;
  reg [2:0] state;
  reg [1:0] op_reg;
  reg [1:0] ctrl_reg;
  reg abnormal;
  reg done_pending;
  reg [7:0] tx_data;
  reg [7:0] rx_data;
  reg [`FDHQ_EV_WIDTH-1:0] int_status;
  reg [`FDHQ_EV_WIDTH-1:0] int_enable;
  reg [15:0] flux_count;
  reg [15:0] cell_count;
  reg [31:0] rate_cnt;
  reg raw_prev;
  reg sec_prev;
  reg opr_strobe_prev;
  reg ccr_strobe_prev;
  reg access_prev;

  wire dma_irq_output_enable = op_reg[`FDHQ_OPR_DMA_EN];
  wire mode_base = (mode == `FDHQ_MODE_BASE);
  wire mode_compat = (mode == `FDHQ_MODE_COMPAT);
  wire ack_seen = ~dma_acknowledge_in_n;
  wire busy = (state == ST_EXEC);

  // Host side access decode. A DMA acknowledge acts as a chip select with
  // the data port addressed.
  wire host_rd = ~host_rd_n;
  wire host_wr = ~host_wr_n;
  wire data_sel = (~host_cs_n & host_a0) | ack_seen;
  wire status_sel = ~host_cs_n & ~host_a0;
  wire data_access = data_sel & (host_rd | host_wr);
  wire access_start = data_access & ~access_prev;
  // Status writes are illegal and are simply dropped.
  wire data_write = access_start & host_wr;

  // Terminal count qualification per mode.
  reg count_taken;
  wire count_qualified = transfer_count_done & ack_seen;
  always @* begin
    count_taken = 1'b0;
    if (mode_compat) begin
      count_taken = count_qualified;
    end else if (mode_base) begin
      count_taken = dma_mode ? count_qualified : transfer_count_done;
    end else begin
      count_taken = dma_irq_output_enable ? count_qualified : transfer_count_done;
    end
  end

  // Load strobes are the decode inputs gated with the write strobe.
  wire opr_strobe = ~operation_reg_load_decode_n & host_wr;
  wire ccr_strobe = ~control_reg_load_decode_n & host_wr;
  wire opr_load = opr_strobe & ~opr_strobe_prev;
  wire ccr_load = ccr_strobe & ~ccr_strobe_prev;

  wire flux_edge = raw_prev & ~raw_read_stream;
  wire sec_rise = second_rate_clock & ~sec_prev;

  // APB decode.
  wire apb_access = psel & penable & ~pready;
  wire apb_write = psel & penable & pready & pwrite;
  wire apb_mapped = (paddr == `FDHQ_OFF_CTRL) || (paddr == `FDHQ_OFF_STATUS) ||
                    (paddr == `FDHQ_OFF_TXDATA) || (paddr == `FDHQ_OFF_RXDATA) ||
                    (paddr == `FDHQ_OFF_INT_STATUS) || (paddr == `FDHQ_OFF_INT_CLEAR) ||
                    (paddr == `FDHQ_OFF_INT_ENABLE) || (paddr == `FDHQ_OFF_COUNTS);
  wire start_cmd = apb_write & (paddr == `FDHQ_OFF_CTRL) & pwdata[`FDHQ_CTRL_START];

  // Bit cell divider. The 300 kbs cell counts rising edges of the second clock, so
  // that rate can only come from the control register setting.
  reg [31:0] rate_limit;
  reg use_second;
  always @* begin
    rate_limit = `FDHQ_DIV_500K;
    use_second = 1'b0;
    case (ctrl_reg)
      `FDHQ_RATE_500K: begin
        rate_limit = `FDHQ_DIV_500K;
      end
      `FDHQ_RATE_300K: begin
        rate_limit = `FDHQ_DIV_300K;
        use_second = 1'b1;
      end
      `FDHQ_RATE_250K: begin
        rate_limit = `FDHQ_DIV_250K;
      end
      `FDHQ_RATE_125K: begin
        rate_limit = `FDHQ_DIV_125K;
      end
      default: begin
        rate_limit = `FDHQ_DIV_500K;
      end
    endcase
  end
  wire rate_step = use_second ? sec_rise : 1'b1;
  wire cell_tick = rate_step & (rate_cnt >= rate_limit - 32'h1);

  // Event collection; hardware set wins over a software clear.
  wire [`FDHQ_EV_WIDTH-1:0] ev_set;
  assign ev_set[`FDHQ_EV_DONE] = busy & count_taken;
  assign ev_set[`FDHQ_EV_HOST_WR] = data_write;
  assign ev_set[`FDHQ_EV_FLUX] = flux_edge;
  assign ev_set[`FDHQ_EV_OPR_LOAD] = opr_load;
  assign ev_set[`FDHQ_EV_CCR_LOAD] = ccr_load;
  wire [`FDHQ_EV_WIDTH-1:0] ev_clr = (apb_write && paddr == `FDHQ_OFF_INT_CLEAR) ?
                                     pwdata[`FDHQ_EV_WIDTH-1:0] : {`FDHQ_EV_WIDTH{1'b0}};
  wire [`FDHQ_EV_WIDTH-1:0] next_int_status = (int_status & ~ev_clr) | ev_set;

  // Host interrupt pin value.
  wire next_host_irq = done_pending | (~dma_mode & busy & ~data_access);
  wire done_clear = access_start & host_rd & ~ack_seen;

  // Sequencer and command state.
  always @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      mode <= `FDHQ_MODE_BASE;
      dma_mode <= 1'b0;
      abnormal <= 1'b0;
      done_pending <= 1'b0;
    end else begin
      if (apb_write && paddr == `FDHQ_OFF_CTRL) begin
        mode <= pwdata[`FDHQ_CTRL_MODE_HI:`FDHQ_CTRL_MODE_LO];
        dma_mode <= pwdata[`FDHQ_CTRL_DMA_MODE];
      end
      case (state)
        ST_IDLE: begin
          if (start_cmd) begin
            state <= ST_EXEC;
            abnormal <= 1'b0;
          end
        end
        ST_EXEC: begin
          if (count_taken) begin
            state <= ST_DONE;
            abnormal <= mode_compat & ~dma_mode;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (busy && count_taken) begin
        done_pending <= 1'b1;
      end else if (done_clear) begin
        done_pending <= 1'b0;
      end
    end
  end

  // Host pin registers and edge history.
  always @(posedge clk_sys) begin
    if (rst) begin
      op_reg <= `FDHQ_OPR_RESET;
      ctrl_reg <= `FDHQ_CCR_RESET;
      rx_data <= 8'h00;
      raw_prev <= 1'b1;
      sec_prev <= 1'b0;
      opr_strobe_prev <= 1'b0;
      ccr_strobe_prev <= 1'b0;
      access_prev <= 1'b0;
      flux_count <= 16'h0000;
      cell_count <= 16'h0000;
      rate_cnt <= 32'h0;
    end else begin
      raw_prev <= raw_read_stream;
      sec_prev <= second_rate_clock;
      opr_strobe_prev <= opr_strobe;
      ccr_strobe_prev <= ccr_strobe;
      access_prev <= data_access;
      if (opr_load) begin
        op_reg <= host_db_in[1:0];
      end
      if (ccr_load) begin
        ctrl_reg <= host_db_in[1:0];
      end
      if (data_write) begin
        rx_data <= host_db_in;
      end
      if (flux_edge) begin
        flux_count <= flux_count + 16'h1;
      end
      if (cell_tick) begin
        rate_cnt <= 32'h0;
        cell_count <= cell_count + 16'h1;
      end else if (rate_step) begin
        rate_cnt <= rate_cnt + 32'h1;
      end
    end
  end

  // Host data bus, request and interrupt pins. Request and interrupt are
  // held as a value with its own enable so the bus can float them when the
  // host leaves the enable bit clear outside base mode.
  wire pins_enabled = mode_base | dma_irq_output_enable;
  wire [7:0] main_status = {~busy | ~data_access, dma_mode, ~dma_mode & busy, busy,
                            abnormal, 1'b0, op_reg};
  reg [7:0] next_db_out;
  reg next_db_oe;
  always @* begin
    next_db_out = 8'h00;
    next_db_oe = 1'b0;
    if (host_rd && data_sel) begin
      next_db_out = tx_data;
      next_db_oe = 1'b1;
    end else if (host_rd && status_sel) begin
      next_db_out = main_status;
      next_db_oe = 1'b1;
    end else if (host_rd && ~control_reg_load_decode_n && ~media_swap_readback_enable_n) begin
      next_db_out = {~media_swap_status_n, 7'h00};
      next_db_oe = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      host_db_out <= 8'h00;
      host_db_oe <= 1'b0;
      dma_request <= 1'b0;
      dma_request_oe <= 1'b1;
      host_irq <= 1'b0;
      host_irq_oe <= 1'b1;
    end else begin
      host_db_out <= next_db_out;
      host_db_oe <= next_db_oe;
      // A served byte drops the request until its strobe ends.
      dma_request <= dma_mode & busy & ~count_taken & ~data_access;
      dma_request_oe <= pins_enabled;
      host_irq <= next_host_irq;
      host_irq_oe <= pins_enabled;
    end
  end

  // APB slave with one wait state; interrupt block.
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h0;
    case (paddr)
      `FDHQ_OFF_CTRL: begin
        next_prdata = {29'h0, dma_mode, mode};
      end
      `FDHQ_OFF_STATUS: begin
        next_prdata = {16'h0, main_status, 1'b0, host_irq, dma_request, abnormal,
                       op_reg, ctrl_reg};
      end
      `FDHQ_OFF_TXDATA: begin
        next_prdata = {24'h0, tx_data};
      end
      `FDHQ_OFF_RXDATA: begin
        next_prdata = {24'h0, rx_data};
      end
      `FDHQ_OFF_INT_STATUS: begin
        next_prdata = {{(32 - `FDHQ_EV_WIDTH){1'b0}}, int_status};
      end
      `FDHQ_OFF_INT_ENABLE: begin
        next_prdata = {{(32 - `FDHQ_EV_WIDTH){1'b0}}, int_enable};
      end
      `FDHQ_OFF_COUNTS: begin
        next_prdata = {cell_count, flux_count};
      end
      default: begin
        next_prdata = 32'h0;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      tx_data <= 8'h00;
      int_status <= {`FDHQ_EV_WIDTH{1'b0}};
      int_enable <= {`FDHQ_EV_WIDTH{1'b0}};
      irq <= 1'b0;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access & ~apb_mapped;
      prdata <= (apb_access && !pwrite) ? next_prdata : 32'h0;
      if (apb_write && paddr == `FDHQ_OFF_TXDATA) begin
        tx_data <= pwdata[7:0];
      end
      if (apb_write && paddr == `FDHQ_OFF_INT_ENABLE) begin
        int_enable <= pwdata[`FDHQ_EV_WIDTH-1:0];
      end
      int_status <= next_int_status;
      irq <= |(next_int_status & int_enable);
    end
  end

endmodule

// [test/fdhq_host_model.sv]
`timescale 1ns/10ps
module fdhq_host_model (
  input wire clk_sys,
  input wire [7:0] db_out,
  input wire db_oe,
  output wire [7:0] db_in,
  output logic rd_n,
  output logic wr_n,
  output logic cs_n,
  output logic a0,
  output logic ack_n,
  output logic count_done,
  output logic opld_n,
  output logic crld_n
);
  logic [7:0] hd = 8'h5a;
  // A released bus shows the inverse of the last byte, so stale data never passes.
  assign db_in = db_oe ? db_out : hd;
  initial {rd_n, wr_n, cs_n, ack_n, opld_n, crld_n, a0, count_done} = 8'hfc;
  task load(input logic [1:0] sel, input logic [7:0] d);
    @(posedge clk_sys);
    hd <= d;
    wr_n <= 1'b0;
    a0 <= 1'b1;
    cs_n <= sel != 2'h0;
    opld_n <= sel != 2'h1;
    crld_n <= sel != 2'h2;
    repeat (2) @(posedge clk_sys);
    {wr_n, cs_n, opld_n, crld_n} <= 4'hf;
    hd <= ~d;
  endtask
  task swap_rd(output logic [7:0] q);
    @(posedge clk_sys);
    rd_n <= 1'b0;
    crld_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    q = db_out;
    rd_n <= 1'b1;
    crld_n <= 1'b1;
  endtask
  task term(input logic dk);
    @(posedge clk_sys);
    count_done <= 1'b1;
    ack_n <= !dk;
    repeat (2) @(posedge clk_sys);
    count_done <= 1'b0;
    ack_n <= 1'b1;
  endtask
  task data_rd(output logic [7:0] q);
    @(posedge clk_sys);
    rd_n <= 1'b0;
    cs_n <= 1'b0;
    a0 <= 1'b1;
    repeat (3) @(posedge clk_sys);
    q = db_out;
    rd_n <= 1'b1;
    cs_n <= 1'b1;
  endtask
endmodule

// [test/fdhq_port_properties.sv]
`timescale 1ns/10ps
module fdhq_port_properties (
  input wire clk_sys,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire irq,
  input wire host_rd_n,
  input wire host_wr_n,
  input wire [7:0] host_db_out,
  input wire host_db_oe,
  input wire dma_request_oe,
  input wire host_irq_oe,
  input wire control_reg_load_decode_n,
  input wire media_swap_readback_enable_n,
  input wire media_swap_status_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire rb = !host_rd_n && !control_reg_load_decode_n && !media_swap_readback_enable_n;
  property p_rst_oe;
    disable iff (1'b0) rst |=> dma_request_oe && host_irq_oe;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("enables low after reset");
  property p_rst_out;
    disable iff (1'b0) rst |=> !irq && !pready && !pslverr && !host_db_oe;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared");
  property p_oe_pair;
    dma_request_oe == host_irq_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
  property p_oe_cause;
    $changed(dma_request_oe) |-> $past(psel, 1) || $past(psel, 2) || !$past(host_wr_n, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("enable moved alone");
  property p_db_drive;
    $rose(host_db_oe) |-> !$past(host_rd_n);
  endproperty
  a_db_drive: assert property (p_db_drive) else $error("bus driven unasked");
  property p_db_release;
    host_rd_n [*3] |-> !host_db_oe;
  endproperty
  a_db_release: assert property (p_db_release) else $error("bus not released");
  property p_swap;
    rb ##1 rb |-> host_db_oe && host_db_out == {~$past(media_swap_status_n), 7'h00};
  endproperty
  a_swap: assert property (p_swap) else $error("top bit wrong");
  property p_pready;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_pready: assert property (p_pready) else $error("bus answer timing");
  property p_slverr;
    pslverr |-> pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("error without ready");
  c_swap: cover property (rb ##1 rb);
  c_err: cover property (pslverr);
  c_oe_off: cover property (!dma_request_oe);
endmodule
bind fdhq_port fdhq_port_properties u_chk (.clk_sys, .rst, .psel, .penable, .pready, .pslverr,
  .irq, .host_rd_n, .host_wr_n, .host_db_out, .host_db_oe, .dma_request_oe, .host_irq_oe,
  .control_reg_load_decode_n, .media_swap_readback_enable_n, .media_swap_status_n);

// [test/floppy_host_port_qualification_tb.sv]
`timescale 1ns/10ps
module floppy_host_port_qualification_tb;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, r;
  logic media_swap_readback_enable_n = 1, media_swap_status_n = 1;
  logic raw_read_stream = 1, second_rate_clock = 0;
  wire pready, pslverr, irq, host_db_oe, dma_request, dma_request_oe, host_irq, host_irq_oe;
  wire host_rd_n, host_wr_n, host_cs_n, host_a0, dma_acknowledge_in_n, transfer_count_done;
  wire operation_reg_load_decode_n, control_reg_load_decode_n;
  wire [31:0] prdata;
  wire [7:0] host_db_out, host_db_in;
  int n_fail = 0, total_checks = 0, cyc = 0;
  fdhq_port DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .irq, .host_rd_n, .host_wr_n, .host_cs_n, .host_a0, .host_db_in, .host_db_out,
    .host_db_oe, .dma_acknowledge_in_n, .transfer_count_done, .dma_request, .dma_request_oe,
    .host_irq, .host_irq_oe, .operation_reg_load_decode_n, .control_reg_load_decode_n,
    .media_swap_readback_enable_n, .media_swap_status_n, .raw_read_stream, .second_rate_clock);
  fdhq_host_model host (.clk_sys, .db_out(host_db_out), .db_oe(host_db_oe), .db_in(host_db_in),
    .rd_n(host_rd_n), .wr_n(host_wr_n), .cs_n(host_cs_n), .a0(host_a0),
    .ack_n(dma_acknowledge_in_n), .count_done(transfer_count_done),
    .opld_n(operation_reg_load_decode_n), .crld_n(control_reg_load_decode_n));
  initial forever #25 clk_sys = ~clk_sys;
  // A stand-in for the second clock, moved on the edge so cell counts stay exact.
  always @(posedge clk_sys) second_rate_clock <= ~second_rate_clock;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_reset;
    chk("req_oe", 32'h1, dma_request_oe);
    apb(0, 8'h04, 32'h0);
    chk("status", 32'h0, r[4:0]);
    $display("t_reset done");
  endtask
  task t_regs;
    host.load(2'h1, 8'hfe);
    apb(0, 8'h04, 32'h0);
    chk("op_reg", 32'h2, r[3:2]);
    chk("base_oe", 32'h1, dma_request_oe);
    host.load(2'h2, 8'h05);
    apb(0, 8'h04, 32'h0);
    chk("ctrl_reg", 32'h1, r[1:0]);
    host.load(2'h0, 8'ha5);
    apb(0, 8'h0c, 32'h0);
    chk("rx", 32'ha5, r[7:0]);
    apb(1, 8'h00, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("oe_off", 32'h0, host_irq_oe);
    host.load(2'h1, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("oe_on", 32'h1, dma_request_oe);
    $display("t_regs done");
  endtask
  task t_swap;
    logic [7:0] q;
    media_swap_readback_enable_n <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      media_swap_status_n <= s[0];
      host.swap_rd(q);
      chk("swap", {24'h0, ~s[0], 7'h00}, q);
    end
    $display("t_swap done");
  endtask
  task t_tc;
    logic [31:0] c [4] = '{32'h8, 32'hc, 32'h9, 32'ha};
    logic e0 [4] = '{1, 0, 0, 0};
    logic ab [4] = '{0, 0, 0, 1};
    logic [7:0] q;
    apb(1, 8'h08, 32'h3c);
    // Base PIO, base DMA, special with enable set, then compatibility with programmed I/O.
    for (int i = 0; i < 4; i++) begin
      apb(1, 8'h14, 32'h1f);
      apb(1, 8'h00, c[i]);
      repeat (2) @(posedge clk_sys);
      chk("busy_irq", !c[i][2], host_irq);
      chk("dma_req", c[i][2], dma_request);
      host.term(1'b0);
      apb(0, 8'h10, 32'h0);
      chk("done_raw", e0[i], r[0]);
      if (!e0[i]) begin
        host.term(1'b1);
        apb(0, 8'h10, 32'h0);
        chk("done_dma_acknowledge_in", 32'h1, r[0]);
      end
      chk("host_irq", 32'h1, host_irq);
      apb(0, 8'h04, 32'h0);
      chk("abnormal", ab[i], r[4]);
      host.data_rd(q);
      chk("host_rd", 32'h3c, q);
      chk("irq_clear", 32'h0, host_irq);
    end
    $display("t_tc done");
  endtask
  task t_rate;
    logic [15:0] n0;
    // 300 kbs: 32 second clock rises a cell; 500 kbs: 40 system cycles a cell.
    for (int k = 0; k < 2; k++) begin
      host.load(2'h2, k ? 8'h00 : 8'h01);
      apb(0, 8'h1c, 32'h0);
      n0 = r[31:16];
      repeat (k ? 396 : 636) @(posedge clk_sys);
      apb(0, 8'h1c, 32'h0);
      chk("cells", n0 + 16'ha, r[31:16]);
    end
    $display("t_rate done");
  endtask
  task t_irq;
    for (int i = 0; i < 3; i++) begin
      apb(1, i == 2 ? 8'h14 : 8'h18, {31'h0, i != 0});
      repeat (2) @(posedge clk_sys);
      chk("irq", {31'h0, i == 1}, irq);
    end
    apb(0, 8'h20, 32'h0);
    chk("slverr", 32'h1, err);
    chk("bad_rd", 32'h0, r);
    $display("t_irq done");
  endtask
  task t_flux;
    logic [15:0] n0;
    apb(0, 8'h1c, 32'h0);
    n0 = r[15:0];
    repeat (3) begin
      @(posedge clk_sys);
      raw_read_stream <= 1'b0;
      repeat (4) @(posedge clk_sys);
      raw_read_stream <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    apb(0, 8'h1c, 32'h0);
    chk("flux", n0 + 16'h3, r[15:0]);
    $display("t_flux done");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_swap();
    t_tc();
    t_irq();
    t_flux();
    t_rate();
    finish_test();
  end
endmodule
